//--- rtl/asrc_route_pkg.sv
package asrc_route_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [15:0] RATE_REG_BASE = 16'hF140;
    localparam logic [15:0] SOURCE_REG_BASE = 16'hF180;
    localparam int NUM_CONVERTERS = 8;
    localparam int NUM_PAIRS = 24;
    localparam logic [15:0] RATE_REG_COUNT = 16'h0008;
    localparam logic [15:0] SOURCE_REG_COUNT = 16'h0018;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int RATE_SEL_LSB = 0;
    localparam int RATE_SEL_MSB = 3;
    localparam int ORIGIN_LSB = 0;
    localparam int ORIGIN_MSB = 2;
    localparam int PICK_LSB = 3;
    localparam int PICK_MSB = 5;
    localparam logic [3:0] RATE_SEL_RESET = 4'h0;
    localparam logic [2:0] ORIGIN_RESET = 3'h0;
    localparam logic [2:0] PICK_RESET = 3'h0;

    // ----------------------------------------------------------------
    // target rate selector codes
    // ----------------------------------------------------------------
    localparam logic [3:0] RATE_NONE = 4'h0;
    localparam logic [3:0] RATE_PORT0 = 4'h1;
    localparam logic [3:0] RATE_PORT1 = 4'h2;
    localparam logic [3:0] RATE_PORT2 = 4'h3;
    localparam logic [3:0] RATE_PORT3 = 4'h4;
    localparam logic [3:0] RATE_CORE = 4'h5;
    localparam logic [3:0] RATE_GEN1_X1 = 4'h6;
    localparam logic [3:0] RATE_GEN1_X2 = 4'h7;
    localparam logic [3:0] RATE_GEN1_X4 = 4'h8;
    localparam logic [3:0] RATE_GEN1_D2 = 4'h9;
    localparam logic [3:0] RATE_GEN2_D3 = 4'hA;
    localparam logic [3:0] RATE_GEN1_D4 = 4'hB;
    localparam logic [3:0] RATE_GEN2_D6 = 4'hC;

    // ----------------------------------------------------------------
    // output pair origin codes
    // ----------------------------------------------------------------
    localparam logic [2:0] ORIGIN_OFF = 3'h0;
    localparam logic [2:0] ORIGIN_SERIAL_IN = 3'h1;
    localparam logic [2:0] ORIGIN_DSP = 3'h2;
    localparam logic [2:0] ORIGIN_CONVERTER = 3'h3;
    localparam logic [2:0] ORIGIN_MIC_01 = 3'h4;
    localparam logic [2:0] ORIGIN_MIC_23 = 3'h5;

    // ----------------------------------------------------------------
    // datapath sizes and rate dividers
    // ----------------------------------------------------------------
    localparam int SAMPLE_W = 32;
    localparam int PAIR_W = 2 * SAMPLE_W;
    localparam int NUM_CHANNELS = 2 * NUM_PAIRS;
    localparam int NUM_CONV_CHANNELS = 2 * NUM_CONVERTERS;
    localparam int NUM_MIC_CHANNELS = 4;
    localparam int DIV_HALF = 2;
    localparam int DIV_THIRD = 3;
    localparam int DIV_QUARTER = 4;
    localparam int DIV_SIXTH = 6;
endpackage : asrc_route_pkg

//--- rtl/tick_divider.sv
`timescale 1ns/1ps
module tick_divider
    import asrc_route_pkg::*;
#(
    parameter int unsigned RATIO = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // rate strobes
    input wire logic tick_in,
    output logic tick_out
);
    localparam int W = $clog2(RATIO);
    localparam logic [W-1:0] LAST = W'(RATIO - 1);

    logic [W-1:0] cnt_q;

    // one output strobe for every RATIO input strobes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_q == LAST) begin
                    cnt_q <= '0;
                    tick_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + W'(1);
                end
            end
        end
    end
endmodule : tick_divider

//--- rtl/pair_router.sv
`timescale 1ns/1ps
module pair_router
    import asrc_route_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // selection
    input wire logic [2:0] origin,
    input wire logic [2:0] pick,
    // candidate sources
    input wire logic [PAIR_W-1:0] serial_pair,
    input wire logic [PAIR_W-1:0] dsp_pair,
    input wire logic [NUM_CONV_CHANNELS*SAMPLE_W-1:0] conv_data,
    input wire logic [NUM_MIC_CHANNELS*SAMPLE_W-1:0] mic_data,
    // routed pair
    output logic [PAIR_W-1:0] pair_q,
    output logic enabled_q
);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pair_q <= '0;
            enabled_q <= 1'b0;
        end else begin
            enabled_q <= (origin != ORIGIN_OFF);
            case (origin)
                ORIGIN_SERIAL_IN: pair_q <= serial_pair;
                ORIGIN_DSP: pair_q <= dsp_pair;
                // pick is looked at only for the converter origin
                ORIGIN_CONVERTER: begin
                    pair_q <= conv_data[pick*PAIR_W +: PAIR_W];
                end
                ORIGIN_MIC_01: pair_q <= mic_data[0 +: PAIR_W];
                ORIGIN_MIC_23: pair_q <= mic_data[PAIR_W +: PAIR_W];
                // disabled and undefined origins send silence
                default: begin
                    pair_q <= '0;
                    enabled_q <= 1'b0;
                end
            endcase
        end
    end
endmodule : pair_router

//--- rtl/target_rate_selector_and_output_routing.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - 4-bit rate selector per converter, resets to zero, zero selects none
// - codes 1 to 4 follow serial output ports 0 to 3
// - code 5 follows the core audio frame rate
// - code 6 follows the base rate of rate generator one
// - codes 7 and 8 follow twice and four times generator one
// - codes 9 and 11 follow half and quarter of generator one
// - codes 10 and 12 follow one third and one sixth of generator two
// - 24 source registers, register k governs channels 2k and 2k+1
// - source registers 0 to 7 feed serial output port 0
// - source registers 8 to 15 feed serial output port 1
// - source registers 16 to 19 feed serial output port 2
// - source registers 20 to 23 feed serial output port 3
// - converter pick at bits 5:3 counts only for the converter origin
// - pick n routes converter channels 2n and 2n+1
// - origin 0 off, 1 serial in, 2 dsp, 3 converter, 4 and 5 mics
// - each converter resamples to the target rate chosen by its register
module target_rate_selector_and_output_routing
    import asrc_route_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // rate strobes from the rest of the device
    input wire logic [3:0] out_port_frame_tick,
    input wire logic core_frame_tick,
    input wire logic gen1_base_tick,
    input wire logic gen1_x2_tick,
    input wire logic gen1_x4_tick,
    input wire logic gen2_base_tick,
    // converter rate targets
    output logic [NUM_CONVERTERS-1:0] target_rate_tick,
    output logic [NUM_CONVERTERS-1:0] target_rate_active,
    // audio sources
    input wire logic [NUM_CHANNELS*SAMPLE_W-1:0] serial_in_data,
    input wire logic [NUM_CHANNELS*SAMPLE_W-1:0] dsp_out_data,
    input wire logic [NUM_CONV_CHANNELS*SAMPLE_W-1:0] conv_out_data,
    input wire logic [NUM_MIC_CHANNELS*SAMPLE_W-1:0] mic_data,
    // routed serial output channels
    output logic [16*SAMPLE_W-1:0] serial_out_port_0,
    output logic [16*SAMPLE_W-1:0] serial_out_port_1,
    output logic [8*SAMPLE_W-1:0] serial_out_port_2,
    output logic [8*SAMPLE_W-1:0] serial_out_port_3,
    output logic [NUM_PAIRS-1:0] pair_enabled
);
    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [3:0] rate_sel_q [NUM_CONVERTERS];
    logic [2:0] origin_q [NUM_PAIRS];
    logic [2:0] pick_q [NUM_PAIRS];

    logic [15:0] rate_off;
    logic [15:0] src_off;
    logic rate_hit;
    logic src_hit;
    logic [2:0] rate_idx;
    logic [4:0] src_idx;

    assign rate_off = reg_addr - RATE_REG_BASE;
    assign src_off = reg_addr - SOURCE_REG_BASE;
    // the subtraction wraps below the base, so one compare suffices
    assign rate_hit = (rate_off < RATE_REG_COUNT);
    assign src_hit = (src_off < SOURCE_REG_COUNT);
    assign rate_idx = rate_off[2:0];
    assign src_idx = src_off[4:0];

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // reserved bits are not stored; they read back as zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CONVERTERS; i++) begin
                rate_sel_q[i] <= RATE_SEL_RESET;
            end
        end else if (reg_wr && rate_hit) begin
            rate_sel_q[rate_idx] <= reg_wdata[RATE_SEL_MSB:RATE_SEL_LSB];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_PAIRS; i++) begin
                origin_q[i] <= ORIGIN_RESET;
                pick_q[i] <= PICK_RESET;
            end
        end else if (reg_wr && src_hit) begin
            origin_q[src_idx] <= reg_wdata[ORIGIN_MSB:ORIGIN_LSB];
            pick_q[src_idx] <= reg_wdata[PICK_MSB:PICK_LSB];
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd && rate_hit) begin
            reg_rdata <= {12'h000, rate_sel_q[rate_idx]};
        end else if (reg_rd && src_hit) begin
            reg_rdata <= {10'h000, pick_q[src_idx], origin_q[src_idx]};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // derived internal rates
    // ----------------------------------------------------------------
    logic gen1_half_tick;
    logic gen1_quarter_tick;
    logic gen2_third_tick;
    logic gen2_sixth_tick;

    tick_divider #(.RATIO(DIV_HALF)) u_gen1_half (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick_in(gen1_base_tick),
        .tick_out(gen1_half_tick)
    );

    tick_divider #(.RATIO(DIV_QUARTER)) u_gen1_quarter (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick_in(gen1_base_tick),
        .tick_out(gen1_quarter_tick)
    );

    tick_divider #(.RATIO(DIV_THIRD)) u_gen2_third (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick_in(gen2_base_tick),
        .tick_out(gen2_third_tick)
    );

    tick_divider #(.RATIO(DIV_SIXTH)) u_gen2_sixth (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick_in(gen2_base_tick),
        .tick_out(gen2_sixth_tick)
    );

    // ----------------------------------------------------------------
    // converter target rate selection
    // ----------------------------------------------------------------
    // the converters lock to target_rate_tick and resample onto it
    genvar c;
    generate
        for (c = 0; c < NUM_CONVERTERS; c++) begin : g_rate
            logic tick_d;
            logic active_d;

            always_comb begin
                tick_d = 1'b0;
                active_d = 1'b1;
                case (rate_sel_q[c])
                    RATE_PORT0: tick_d = out_port_frame_tick[0];
                    RATE_PORT1: tick_d = out_port_frame_tick[1];
                    RATE_PORT2: tick_d = out_port_frame_tick[2];
                    RATE_PORT3: tick_d = out_port_frame_tick[3];
                    RATE_CORE: tick_d = core_frame_tick;
                    RATE_GEN1_X1: tick_d = gen1_base_tick;
                    RATE_GEN1_X2: tick_d = gen1_x2_tick;
                    RATE_GEN1_X4: tick_d = gen1_x4_tick;
                    RATE_GEN1_D2: tick_d = gen1_half_tick;
                    RATE_GEN2_D3: tick_d = gen2_third_tick;
                    RATE_GEN1_D4: tick_d = gen1_quarter_tick;
                    RATE_GEN2_D6: tick_d = gen2_sixth_tick;
                    // code zero and the undefined codes select nothing
                    default: active_d = 1'b0;
                endcase
            end

            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    target_rate_tick[c] <= 1'b0;
                    target_rate_active[c] <= 1'b0;
                end else begin
                    target_rate_tick[c] <= tick_d;
                    target_rate_active[c] <= active_d;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // output pair routing
    // ----------------------------------------------------------------
    logic [NUM_CHANNELS*SAMPLE_W-1:0] routed;

    genvar k;
    generate
        for (k = 0; k < NUM_PAIRS; k++) begin : g_pair
            pair_router u_router (
                .clock(clock),
                .sys_rst(sys_rst),
                .origin(origin_q[k]),
                .pick(pick_q[k]),
                .serial_pair(serial_in_data[k*PAIR_W +: PAIR_W]),
                .dsp_pair(dsp_out_data[k*PAIR_W +: PAIR_W]),
                .conv_data(conv_out_data),
                .mic_data(mic_data),
                .pair_q(routed[k*PAIR_W +: PAIR_W]),
                .enabled_q(pair_enabled[k])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // port grouping
    // ----------------------------------------------------------------
    // ports 2 and 3 carry half as many channels as ports 0 and 1
    assign serial_out_port_0 = routed[0 +: 16*SAMPLE_W];
    assign serial_out_port_1 = routed[16*SAMPLE_W +: 16*SAMPLE_W];
    assign serial_out_port_2 = routed[32*SAMPLE_W +: 8*SAMPLE_W];
    assign serial_out_port_3 = routed[40*SAMPLE_W +: 8*SAMPLE_W];
endmodule : target_rate_selector_and_output_routing

//--- dv/asrc_route_chk.sv
`timescale 1ns/1ps
module asrc_route_chk
    import asrc_route_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // rate strobes
    input wire logic [3:0] out_port_frame_tick,
    input wire logic core_frame_tick,
    input wire logic gen1_base_tick,
    input wire logic gen1_x2_tick,
    input wire logic [NUM_CONVERTERS-1:0] target_rate_tick,
    input wire logic [NUM_CONVERTERS-1:0] target_rate_active,
    // audio
    input wire logic [NUM_CHANNELS*SAMPLE_W-1:0] serial_in_data,
    input wire logic [NUM_CHANNELS*SAMPLE_W-1:0] dsp_out_data,
    input wire logic [NUM_CONV_CHANNELS*SAMPLE_W-1:0] conv_out_data,
    input wire logic [NUM_MIC_CHANNELS*SAMPLE_W-1:0] mic_data,
    input wire logic [16*SAMPLE_W-1:0] serial_out_port_0,
    input wire logic [NUM_PAIRS-1:0] pair_enabled
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // shadows of converter 0 rate and pair 0 source
    // ----------------------------------------------------------------
    logic [3:0] rate0_q;
    logic [5:0] src0_q;
    logic [63:0] exp0;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rate0_q <= 4'h0;
        end else if (reg_wr && reg_addr == RATE_REG_BASE) begin
            rate0_q <= reg_wdata[3:0];
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            src0_q <= 6'h00;
        end else if (reg_wr && reg_addr == SOURCE_REG_BASE) begin
            src0_q <= reg_wdata[5:0];
        end
    end
    always_comb begin
        case (src0_q[2:0])
            3'h1: exp0 = serial_in_data[63:0];
            3'h2: exp0 = dsp_out_data[63:0];
            3'h3: exp0 = conv_out_data[src0_q[5:3]*64 +: 64];
            3'h4: exp0 = mic_data[63:0];
            3'h5: exp0 = mic_data[127:64];
            default: exp0 = 64'h0;
        endcase
    end
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_rd_rate;
        $past(reg_rd) && $past(reg_addr) == RATE_REG_BASE
            |-> reg_rdata == {12'h000, $past(rate0_q)};
    endproperty
    a_rd_rate: assert property (p_rd_rate) else $error("rate readback");
    property p_rd_src;
        $past(reg_rd) && $past(reg_addr) == SOURCE_REG_BASE
            |-> reg_rdata == {10'h000, $past(src0_q)};
    endproperty
    a_rd_src: assert property (p_rd_src) else $error("source readback");
    property p_active;
        target_rate_active[0] ==
            ($past(rate0_q) != 0 && $past(rate0_q) < 4'hD);
    endproperty
    a_active: assert property (p_active) else $error("active level");
    property p_no_tick;
        (target_rate_tick & ~target_rate_active) == 8'h00;
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("idle tick");
    property p_port0;
        $past(rate0_q) == 4'h1 |->
            target_rate_tick[0] == $past(out_port_frame_tick[0]);
    endproperty
    a_port0: assert property (p_port0) else $error("port rate tick");
    property p_core;
        $past(rate0_q) == 4'h5 |->
            target_rate_tick[0] == $past(core_frame_tick);
    endproperty
    a_core: assert property (p_core) else $error("core rate tick");
    property p_gen1;
        $past(rate0_q) == 4'h6 |->
            target_rate_tick[0] == $past(gen1_base_tick);
    endproperty
    a_gen1: assert property (p_gen1) else $error("gen1 rate tick");
    property p_gen1x2;
        $past(rate0_q) == 4'h7 |->
            target_rate_tick[0] == $past(gen1_x2_tick);
    endproperty
    a_gen1x2: assert property (p_gen1x2) else $error("gen1 x2 tick");
    property p_pair0; serial_out_port_0[63:0] == $past(exp0); endproperty
    a_pair0: assert property (p_pair0) else $error("pair 0 data");
    property p_pair0_en;
        pair_enabled[0] ==
            ($past(src0_q[2:0]) != 0 && $past(src0_q[2:0]) < 3'h6);
    endproperty
    a_pair0_en: assert property (p_pair0_en) else $error("pair 0 en");
endmodule : asrc_route_chk

bind target_rate_selector_and_output_routing asrc_route_chk asrc_route_chk_inst (
    .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .out_port_frame_tick, .core_frame_tick, .gen1_base_tick, .gen1_x2_tick,
    .target_rate_tick, .target_rate_active, .serial_in_data, .dsp_out_data,
    .conv_out_data, .mic_data, .serial_out_port_0, .pair_enabled
);

//--- dv/target_rate_selector_and_output_routing_tb_top.sv
`timescale 1ns/1ps
module target_rate_selector_and_output_routing_tb_top
    import asrc_route_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    // {port3..port0, core, gen1, gen1 x2, gen1 x4, gen2}
    logic [8:0] src = 9'h000;
    logic [NUM_CHANNELS*SAMPLE_W-1:0] sin_d, dsp_d;
    logic [NUM_CONV_CHANNELS*SAMPLE_W-1:0] conv_d;
    logic [NUM_MIC_CHANNELS*SAMPLE_W-1:0] mic_d;
    logic [15:0] reg_rdata;
    logic [7:0] tick, act;
    logic [16*SAMPLE_W-1:0] p0, p1;
    logic [8*SAMPLE_W-1:0] p2, p3;
    logic [23:0] pen;
    wire [NUM_CHANNELS*SAMPLE_W-1:0] all_out = {p3, p2, p1, p0};
    int bad_count = 0;
    int checks = 0;
    int tick_cnt = 0;

    target_rate_selector_and_output_routing target_rate_selector_and_output_routing_inst (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .out_port_frame_tick(src[8:5]),
        .core_frame_tick(src[4]), .gen1_base_tick(src[3]),
        .gen1_x2_tick(src[2]), .gen1_x4_tick(src[1]),
        .gen2_base_tick(src[0]), .target_rate_tick(tick),
        .target_rate_active(act), .serial_in_data(sin_d),
        .dsp_out_data(dsp_d), .conv_out_data(conv_d), .mic_data(mic_d),
        .serial_out_port_0(p0), .serial_out_port_1(p1),
        .serial_out_port_2(p2), .serial_out_port_3(p3), .pair_enabled(pen)
    );

    always #5 clock = ~clock;
    always @(posedge clock) if (tick[0] === 1'b1) tick_cnt <= tick_cnt + 1;

    task automatic cmp(input string what, input logic [63:0] e,
                       input logic [63:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        cmp("reg_rdata", {48'h0, e}, {48'h0, reg_rdata});
    endtask : rd
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // refused codes pulse every source so a leak shows up
    function automatic logic [8:0] src_of(input logic [3:0] c);
        case (c)
            4'h1, 4'h2, 4'h3, 4'h4: return 9'h010 << c;
            4'h5: return 9'h010;
            4'h6, 4'h9, 4'hB: return 9'h008;
            4'h7: return 9'h004;
            4'h8: return 9'h002;
            4'hA, 4'hC: return 9'h001;
            default: return 9'h1FF;
        endcase
    endfunction : src_of
    function automatic int per12(input int c);
        case (c)
            4'h9: return 6;
            4'hA: return 4;
            4'hB: return 3;
            4'hC: return 2;
            default: return (c != 0 && c < 4'h9) ? 12 : 0;
        endcase
    endfunction : per12
    function automatic logic [63:0] exp_pair(input int k, input int o,
                                             input int p);
        case (o)
            1: return sin_d[k*64 +: 64];
            2: return dsp_d[k*64 +: 64];
            3: return conv_d[p*64 +: 64];
            4: return mic_d[63:0];
            5: return mic_d[127:64];
            default: return 64'h0;
        endcase
    endfunction : exp_pair

    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            sin_d[i*32 +: 32] = 32'h1000_0000 + i;
            dsp_d[i*32 +: 32] = 32'h2000_0000 + i;
        end
        for (int i = 0; i < NUM_CONV_CHANNELS; i++) begin
            conv_d[i*32 +: 32] = 32'h3000_0000 + i;
        end
        for (int i = 0; i < NUM_MIC_CHANNELS; i++) begin
            mic_d[i*32 +: 32] = 32'h4000_0000 + i;
        end
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(16'(RATE_REG_BASE + i), 16'h0000);
        for (int i = 0; i < NUM_PAIRS; i++) begin
            rd(16'(SOURCE_REG_BASE + i), 16'h0000);
        end
        cmp("outputs", 64'h0, {24'h0, pen, tick, act} | 64'(|all_out));
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            wr(16'(RATE_REG_BASE + i), 16'(16'hFFF1 + i));
        end
        wr(16'hF148, 16'hFFFF);
        for (int i = 0; i < 8; i++) begin
            rd(16'(RATE_REG_BASE + i), 16'(i + 1));
        end
        rd(16'hF148, 16'h0000);
        rd(16'hF198, 16'h0000);
        cmp("active", 64'hFF, {56'h0, act});
        // codes 1 to 8 on converters 0 to 7: one strobe reaches every one
        @(posedge clock);
        src <= 9'h1FF;
        @(posedge clock);
        src <= 9'h000;
        @(negedge clock);
        cmp("all ticks", 64'hFF, {56'h0, tick});
        $display("rate registers done");
        for (int c = 0; c < 16; c++) begin
            wr(RATE_REG_BASE, {12'hFFF, 4'(c)});
            rd(RATE_REG_BASE, {12'h000, 4'(c)});
            cmp("active 0", 64'(c != 0 && c < 13), {63'h0, act[0]});
            tick_cnt = 0;
            repeat (12) begin
                @(posedge clock);
                src <= src_of(4'(c));
                @(posedge clock);
                src <= 9'h000;
            end
            repeat (4) @(posedge clock);
            cmp("ticks", 64'(per12(c)), 64'(tick_cnt));
        end
        $display("rate codes done");
        for (int s = 0; s < 3; s++) begin
            for (int k = 0; k < NUM_PAIRS; k++) begin
                logic [5:0] f;
                f = {3'(k / 3), 3'(k + 3 * s)};
                wr(16'(SOURCE_REG_BASE + k), {10'h3FF, f});
            end
            repeat (2) @(posedge clock);
            @(negedge clock);
            for (int k = 0; k < NUM_PAIRS; k++) begin
                int o;
                logic [5:0] f;
                logic [63:0] e;
                o = (k + 3 * s) % 8;
                f = {3'(k / 3), 3'(o)};
                e = exp_pair(k, o, k / 3);
                cmp("pair data", e, all_out[k*64 +: 64]);
                cmp("pair en", 64'(o inside {[1:5]}), {63'h0, pen[k]});
                rd(16'(SOURCE_REG_BASE + k), {10'h000, f});
            end
        end
        $display("routing done");
        // a reset in mid-run must clear every register and output again
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(RATE_REG_BASE, 16'h0000);
        rd(SOURCE_REG_BASE, 16'h0000);
        rd(16'hF197, 16'h0000);
        cmp("outputs", 64'h0, {24'h0, pen, tick, act} | 64'(|all_out));
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule : target_rate_selector_and_output_routing_tb_top
